// file: core/ppm_core.sv
// Printer port standard-mode pin logic with an APB register slave.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module ppm_core
#(
  parameter int ADDR_W = 12          // Width of the APB address.
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  output logic                   device_select_out,
  output logic                   printer_reset_out,
  output logic                   line_advance_out,
  output logic                   data_latch_pulse,
  input  wire logic              printer_busy_in,
  output logic                   busy_pin_o,
  output logic                   busy_pin_oe,
  input  wire logic              printer_accepted_in,
  output logic                   accepted_pin_o,
  output logic                   accepted_pin_oe,
  input  wire logic              media_out_status,
  input  wire logic              printer_online_in,
  input  wire logic              fault_in,
  input  wire logic [7:0]        port_line_i,
  output logic      [7:0]        port_line_o,
  output logic      [7:0]        port_line_oe,
  input  wire logic              head_move_pulse,
  input  wire logic              seek_sense_out,
  input  wire logic              drive_sel_0,
  input  wire logic              drive_sel_1,
  input  wire logic              spindle_on_0,
  input  wire logic              spindle_on_1,
  output logic                   rotation_mark_in,
  output logic                   track_zero_in,
  output logic                   write_lock_in,
  output logic                   read_stream_in,
  output logic                   media_changed_in
);

  // The decoder compares address bits 11 to 2, so narrower buses fail.
  if (ADDR_W < 12)
  begin : g_chk
    $error("ADDR_W must be at least 12.");
  end

  // True when the low address bits select the given register word.
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  // Register state.
  logic [7:0]  data_r;               // Host-written port data.
  logic [7:0]  ctl_r;                // Printer control register.
  logic [2:0]  istat_r;              // Sticky event bits.
  logic [2:0]  imask_r;              // Interrupt enables.
  logic [2:0]  istat_nxt;            // Next sticky event bits.
  logic        ack_q;                // Previous accepted level.
  logic        fault_q;              // Previous fault level.
  logic        media_q;              // Previous media-out level.
  logic        od_zero_r;            // Low level for open-drain pins.
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;

  // Bus decode; the access completes on its second cycle.
  wire logic [11:0] a12     = paddr[11:0];
  wire logic        acc     = psel & penable & ~pready_r;
  wire logic        done    = psel & penable & pready_r;
  wire logic        wr      = done & pwrite;
  wire logic        h_data  = hit(a12, ppm_pkg::OFF_DATA);
  wire logic        h_stat  = hit(a12, ppm_pkg::OFF_STAT);
  wire logic        h_ctrl  = hit(a12, ppm_pkg::OFF_CTRL);
  wire logic        h_istat = hit(a12, ppm_pkg::OFF_ISTAT);
  wire logic        h_imask = hit(a12, ppm_pkg::OFF_IMASK);
  wire logic        mapped  = h_data | h_stat | h_ctrl | h_istat
                              | h_imask;
  wire logic        floppy  = ctl_r[ppm_pkg::CTL_FLOPPY];

  // Live status byte; bits 2 to 0 read as zero.
  wire logic [7:0] stat_v = {~printer_busy_in,
                             printer_accepted_in,
                             media_out_status,
                             printer_online_in,
                             fault_in,
                             3'h0};

  // Read data selection; an unmapped address reads zero.
  wire logic [7:0] rd_v = h_data  ? data_r :
                          h_stat  ? stat_v :
                          h_ctrl  ? ctl_r  :
                          h_istat ? {5'h00, istat_r} :
                          h_imask ? {5'h00, imask_r} : 8'h00;

  // Events: accepted and fault falling, media-out rising.
  wire logic [2:0] ev = {media_out_status & ~media_q,
                         fault_q & ~fault_in,
                         ack_q & ~printer_accepted_in};
  wire logic [2:0] w1c = (wr & h_istat) ? pwdata[2:0] : 3'h0;

  // A set in the cycle of its clear wins, so no event is lost.
  assign istat_nxt = (istat_r & ~w1c) | ev;

  // Pin values in each mode, registered below.
  wire logic sel_v   = floppy ? head_move_pulse
                              : ~ctl_r[ppm_pkg::CTL_SEL];
  wire logic rst_v   = floppy ? seek_sense_out
                              : ctl_r[ppm_pkg::CTL_RESET];
  wire logic line_v  = floppy ? 1'b1
                              : ~ctl_r[ppm_pkg::CTL_LINE];
  wire logic latch_v = floppy ? drive_sel_0
                              : ~ctl_r[ppm_pkg::CTL_LATCH];

  // Data lines: driven from the register unless set to input; floppy mode drives only the spindle line, low.
  wire logic [7:0] pd_oe_v = floppy ?
                             (spindle_on_0 ? 8'h00 : ppm_pkg::PD_SPINDLE) :
                             (ctl_r[ppm_pkg::CTL_DIR_IN] ? 8'h00
                                                          : 8'hFF);
  wire logic [7:0] pd_o_v = floppy ? 8'h00 : data_r;

  // Bus handshake and read data; answer one cycle into access.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= acc;
      pslverr_r <= acc & ~mapped;
      prdata_r  <= (acc & ~pwrite) ? {24'h00_0000, rd_v} : 32'h0000_0000;
    end
  end

  // Software registers; writes land on the completing edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_r  <= ppm_pkg::DATA_RST;
      ctl_r   <= ppm_pkg::CTRL_RST;
      imask_r <= ppm_pkg::IMASK_RST;
    end
    else
    begin
      if (wr & h_data)
      begin
        data_r <= pwdata[7:0];
      end
      if (wr & h_ctrl)
      begin
        ctl_r <= pwdata[7:0];
      end
      if (wr & h_imask)
      begin
        imask_r <= pwdata[2:0];
      end
    end
  end

  // Event edge history and sticky status.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_q   <= 1'b1;
      fault_q <= 1'b1;
      media_q <= 1'b0;
      istat_r <= 3'h0;
      irq     <= 1'b0;
    end
    else
    begin
      ack_q   <= printer_accepted_in;
      fault_q <= fault_in;
      media_q <= media_out_status;
      istat_r <= istat_nxt;
      // The interrupt lags the sticky bit by one cycle.
      irq     <= |(istat_r & imask_r);
    end
  end

  // Printer and floppy pins, all from flip-flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      device_select_out <= 1'b1;
      printer_reset_out <= 1'b0;
      line_advance_out  <= 1'b1;
      data_latch_pulse  <= 1'b1;
      port_line_o       <= 8'h00;
      port_line_oe      <= 8'h00;
      busy_pin_oe       <= 1'b0;
      accepted_pin_oe   <= 1'b0;
      od_zero_r         <= 1'b0;
    end
    else
    begin
      device_select_out <= sel_v;
      printer_reset_out <= rst_v;
      line_advance_out  <= line_v;
      data_latch_pulse  <= latch_v;
      port_line_o       <= pd_o_v;
      port_line_oe      <= pd_oe_v;
      // Open-drain floppy outputs only ever pull low.
      busy_pin_oe       <= floppy & ~spindle_on_1;
      accepted_pin_oe   <= floppy & ~drive_sel_1;
      od_zero_r         <= 1'b0;
    end
  end

  // Floppy inputs are held inactive high unless routed here.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rotation_mark_in <= 1'b1;
      track_zero_in    <= 1'b1;
      write_lock_in    <= 1'b1;
      read_stream_in   <= 1'b1;
      media_changed_in <= 1'b1;
    end
    else
    begin
      rotation_mark_in <= ~floppy | port_line_i[0];
      track_zero_in    <= ~floppy | port_line_i[1];
      write_lock_in    <= ~floppy | port_line_i[2];
      read_stream_in   <= ~floppy | port_line_i[3];
      media_changed_in <= ~floppy | port_line_i[4];
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign busy_pin_o     = od_zero_r;
  assign accepted_pin_o = od_zero_r;

  // Checks on the pin mapping and status readback.
  wire logic rd_stat = acc & ~pwrite & h_stat;

  property p_sel;
    @(posedge pclk) disable iff (!presetn)
    !floppy |=> device_select_out == !$past(ctl_r[3]);
  endproperty
  a_sel: assert property (p_sel)
    else $error("Select pin does not invert control bit 3.");

  property p_rst;
    @(posedge pclk) disable iff (!presetn)
    !floppy |=> printer_reset_out == $past(ctl_r[2]);
  endproperty
  a_rst: assert property (p_rst)
    else $error("Reset pin does not follow control bit 2.");

  property p_line;
    @(posedge pclk) disable iff (!presetn)
    !floppy |=> line_advance_out == !$past(ctl_r[1]);
  endproperty
  a_line: assert property (p_line)
    else $error("Line advance pin does not invert bit 1.");

  property p_latch;
    @(posedge pclk) disable iff (!presetn)
    !floppy |=> data_latch_pulse == !$past(ctl_r[0]);
  endproperty
  a_latch: assert property (p_latch)
    else $error("Latch pin does not invert bit 0.");

  property p_busy;
    @(posedge pclk) disable iff (!presetn)
    rd_stat |=> prdata[7] == !$past(printer_busy_in);
  endproperty
  a_busy: assert property (p_busy)
    else $error("Status bit 7 is not inverted busy.");

  property p_ack;
    @(posedge pclk) disable iff (!presetn)
    rd_stat |=> prdata[6] == $past(printer_accepted_in);
  endproperty
  a_ack: assert property (p_ack)
    else $error("Status bit 6 is not the accepted level.");

  property p_media;
    @(posedge pclk) disable iff (!presetn)
    rd_stat |=> prdata[5] == $past(media_out_status);
  endproperty
  a_media: assert property (p_media)
    else $error("Status bit 5 is not the media-out level.");

  property p_online;
    @(posedge pclk) disable iff (!presetn)
    rd_stat |=> prdata[4] == $past(printer_online_in) && pready;
  endproperty
  a_online: assert property (p_online)
    else $error("Status bit 4 is not the online level.");

  property p_fault;
    @(posedge pclk) disable iff (!presetn)
    rd_stat |=> prdata[3] == $past(fault_in) && prdata[2:0] == 3'h0;
  endproperty
  a_fault: assert property (p_fault)
    else $error("Status bit 3 is not the fault level.");

  property p_floppy;
    @(posedge pclk) disable iff (!presetn)
    floppy |=> data_latch_pulse == $past(drive_sel_0)
               && port_line_o == 8'h00;
  endproperty
  a_floppy: assert property (p_floppy)
    else $error("Floppy routing does not reach the pins.");

  property p_pd;
    @(posedge pclk) disable iff (!presetn)
    (!floppy && !ctl_r[5]) |=> port_line_oe == 8'hFF
                               && port_line_o == $past(data_r);
  endproperty
  a_pd: assert property (p_pd)
    else $error("Data lines are not driven from the register.");

  cover property (@(posedge pclk) disable iff (!presetn)
                  wr & h_ctrl);
  cover property (@(posedge pclk) disable iff (!presetn)
                  rd_stat ##1 pready);
  cover property (@(posedge pclk) disable iff (!presetn)
                  ev[0] ##2 irq);
endmodule

// file: core/ppm_pkg.sv
// Constants shared by the printer port pin mapping block.
// Notes on behaviour
// - select output is inverse of control bit 3.
// - reset output follows control bit 2 directly.
// - line advance output is inverse of bit 1.
// - latch pulse output is inverse of bit 0.
// - status bit 6 reads accepted input directly.
// - status bit 5 reads media-out input directly.
// - status bit 4 reads online input directly.
// - status bit 3 reads fault input directly.
// - pins may carry floppy drive functions instead.
package ppm_pkg;
  // Byte offsets of the registers on the bus.
  localparam logic [11:0] OFF_DATA  = 12'h000;
  localparam logic [11:0] OFF_STAT  = 12'h004;
  localparam logic [11:0] OFF_CTRL  = 12'h008;
  localparam logic [11:0] OFF_ISTAT = 12'h00C;
  localparam logic [11:0] OFF_IMASK = 12'h010;
  // Control register field positions.
  localparam int CTL_LATCH  = 0;
  localparam int CTL_LINE   = 1;
  localparam int CTL_RESET  = 2;
  localparam int CTL_SEL    = 3;
  localparam int CTL_DIR_IN = 5;
  localparam int CTL_FLOPPY = 6;
  // Status register field positions.
  localparam int ST_FAULT  = 3;
  localparam int ST_ONLINE = 4;
  localparam int ST_MEDIA  = 5;
  localparam int ST_ACK    = 6;
  localparam int ST_BUSY   = 7;
  // Event bit positions in interrupt status and mask, and their field width.
  localparam int EV_ACK   = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_MEDIA = 2;
  localparam int EV_W     = 3;
  // Reset values.
  localparam logic [7:0] CTRL_RST  = 8'h04;
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [2:0] IMASK_RST = 3'h0;
  // Only the spindle line of the data port is driven in floppy mode.
  localparam logic [7:0] PD_SPINDLE = 8'h40;
endpackage

// file: test/ppm_printer_model.sv
// Behavioural printer that answers the port's data latch strobe.
`timescale 1ns/1ps
module ppm_printer_model
#(
  parameter int HOLD = 4  // Cycles after the strobe until the accept pulse; busy lasts one cycle more.
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic data_latch_pulse,
  input  wire logic paper_empty,
  input  wire logic jammed,
  output logic      printer_busy_in,
  output logic      printer_accepted_in,
  output logic      media_out_status,
  output logic      printer_online_in,
  output logic      fault_in
);
  logic [3:0] cnt_r;  // Cycles left before the byte is taken.

  // Condition levels; online simply follows power, as a real printer does.
  assign media_out_status  = paper_empty;
  assign fault_in          = ~jammed;
  assign printer_online_in = presetn;

  // Busy from the strobe through one accept low that marks the byte taken.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r               <= 4'h0;
      printer_busy_in     <= 1'b0;
      printer_accepted_in <= 1'b1;
    end
    else if (!data_latch_pulse)
    begin
      // A held strobe keeps the printer busy; the count restarts.
      cnt_r           <= 4'(HOLD);
      printer_busy_in <= 1'b1;
    end
    else if (cnt_r != 4'h0)
    begin
      cnt_r               <= cnt_r - 4'h1;
      printer_accepted_in <= (cnt_r != 4'h1);
    end
    else
    begin
      // Busy drops only once the accept pulse has been given.
      printer_accepted_in <= 1'b1;
      printer_busy_in     <= 1'b0;
    end
  end
endmodule

// file: test/tb_printer_port_pin_mapping.sv
// Self-checking bench for the printer port pin mapping block.
`timescale 1ns/1ps
module tb_printer_port_pin_mapping;
  logic        pclk, presetn, psel, penable, pwrite;  // Bus controls.
  logic [11:0] paddr;        // Bus address.
  logic [31:0] pwdata;       // Bus write data.
  logic [31:0] prdata;       // Bus read data.
  logic        pready, pslverr, irq;  // Bus answer and interrupt.
  logic        sel_n, init_n, feed_n, latch_n;  // Printer control pins.
  logic        busy, acc_n, media, online, fault_n;  // Printer status.
  logic [7:0]  pl_i, pl_o, pl_oe, pd_ext;  // Data lines and far drive.
  logic [5:0]  fl;           // Floppy controller levels.
  logic [4:0]  fo;           // Floppy status outputs.
  logic        bo, boe, ao, aoe;  // Floppy open-drain pins and enables.
  logic        paper, jam;   // Printer conditions.
  logic [31:0] q;            // Last read data.
  logic        e;            // Last error answer.
  int          errors, checks_done, cyc;

  // The far side drives only the lines the port has released.
  assign pl_i = (pl_oe & pl_o) | (~pl_oe & pd_ext);

  ppm_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .device_select_out(sel_n), .printer_reset_out(init_n),
    .line_advance_out(feed_n), .data_latch_pulse(latch_n),
    .printer_busy_in(busy), .busy_pin_o(bo), .busy_pin_oe(boe),
    .printer_accepted_in(acc_n), .accepted_pin_o(ao),
    .accepted_pin_oe(aoe),
    .media_out_status(media), .printer_online_in(online),
    .fault_in(fault_n), .port_line_i(pl_i), .port_line_o(pl_o),
    .port_line_oe(pl_oe), .head_move_pulse(fl[0]),
    .seek_sense_out(fl[1]), .drive_sel_0(fl[2]), .drive_sel_1(fl[3]),
    .spindle_on_0(fl[4]), .spindle_on_1(fl[5]),
    .rotation_mark_in(fo[0]), .track_zero_in(fo[1]),
    .write_lock_in(fo[2]), .read_stream_in(fo[3]),
    .media_changed_in(fo[4]));

  ppm_printer_model prn (.pclk(pclk), .presetn(presetn),
    .data_latch_pulse(latch_n), .paper_empty(paper), .jammed(jam),
    .printer_busy_in(busy), .printer_accepted_in(acc_n),
    .media_out_status(media), .printer_online_in(online),
    .fault_in(fault_n));

  // Free-running bus clock at 200 MHz.
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Prints the verdict and ends the run.
  task automatic summarize;
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string       n,
                     input logic [31:0] x,
                     input logic [31:0] s);
    checks_done++;
    if (s !== x)
    begin
      $display("unexpected %s expected %h seen %h", n, x, s);
      errors++;
    end
  endtask

  // One bus transfer; the answer is taken at the edge that samples pready.
  task automatic xfer(input logic        w,
                      input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The request stands until the rising edge that sees pready high.
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Lets a control change reach the registered pins.
  task automatic settle;
    repeat (3) @(negedge pclk);
  endtask

  // Each pattern of control bits 3 to 0 reaches the four control pins.
  task automatic t_ctrl;
    for (int i = 0; i < 16; i++)
    begin
      xfer(1'b1, ppm_pkg::OFF_CTRL, 32'(i));
      settle();
      chk("pins", 32'({~i[3], i[2], ~i[1], ~i[0]}),
          32'({sel_n, init_n, feed_n, latch_n}));
    end
    xfer(1'b1, ppm_pkg::OFF_CTRL, 32'h00000004);
  endtask

  // Data lines follow the data register and release for input.
  task automatic t_data;
    xfer(1'b1, ppm_pkg::OFF_DATA, 32'h000000A5);
    settle();
    chk("lines", 32'h0000FFA5, {16'h0, pl_oe, pl_o});
    xfer(1'b1, ppm_pkg::OFF_CTRL, 32'h00000024);
    settle();
    chk("line_enables", 32'h00000000, {24'h0, pl_oe});
    xfer(1'b1, ppm_pkg::OFF_CTRL, 32'h00000004);
  endtask

  // Status bits while busy with faults, events and a masked interrupt.
  task automatic t_status;
    xfer(1'b1, ppm_pkg::OFF_ISTAT, 32'h00000007);
    xfer(1'b1, ppm_pkg::OFF_IMASK, 32'h00000001);
    xfer(1'b0, ppm_pkg::OFF_STAT, 32'h0);
    chk("idle_status", 32'h000000D8, q);
    paper <= 1'b1;
    jam   <= 1'b1;
    xfer(1'b1, ppm_pkg::OFF_CTRL, 32'h00000005);
    xfer(1'b0, ppm_pkg::OFF_STAT, 32'h0);
    chk("busy_status", 32'h00000070, q);
    chk("masked_irq", 32'h0, {31'h0, irq});
    xfer(1'b1, ppm_pkg::OFF_CTRL, 32'h00000004);
    repeat (12) @(negedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    xfer(1'b0, ppm_pkg::OFF_ISTAT, 32'h0);
    chk("events", 32'h00000007, q);
    xfer(1'b1, ppm_pkg::OFF_ISTAT, 32'h00000007);
    settle();
    chk("cleared_irq", 32'h0, {31'h0, irq});
    @(posedge pclk);
    paper <= 1'b0;
    jam   <= 1'b0;
  endtask

  // Floppy routing moves the pins over to the drive signals.
  task automatic t_floppy;
    fl     <= 6'h06;
    pd_ext <= 8'h02;
    xfer(1'b1, ppm_pkg::OFF_CTRL, 32'h00000044);
    settle();
    chk("floppy_pins", 32'h00007C40, {16'h0, sel_n, init_n, feed_n,
        latch_n, boe, aoe, bo, ao, pl_oe});
    chk("drive_in", 32'h02, {27'h0, fo});
    @(posedge pclk);
    fl <= 6'h3F;
    settle();
    chk("floppy_pins", 32'h0000F000, {16'h0, sel_n, init_n, feed_n,
        latch_n, boe, aoe, bo, ao, pl_oe});
    xfer(1'b1, ppm_pkg::OFF_CTRL, 32'h00000004);
    settle();
    chk("drive_idle", 32'h1F, {27'h0, fo});
  endtask

  // Cuts a hang short.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors++;
      summarize();
    end
  end

  // Main sequence: reset, reset values, then each scenario.
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {paper, jam, errors, checks_done, cyc} = '0;
    fl     = 6'h3F;
    pd_ext = 8'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, ppm_pkg::OFF_CTRL, 32'h0);
    chk("ctrl_reset", 32'h00000004, q);
    chk("reset_pins", 32'hF, 32'({sel_n, init_n, feed_n, latch_n}));
    xfer(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    t_ctrl();
    t_data();
    t_status();
    t_floppy();
    summarize();
  end
endmodule
